// File: hdl/pnp_card_defs.svh
/*
 * Constants of the card-side Plug and Play isolation and resource logic.
 * Assumes the includer places these in a module or package scope.
 */
// Function
// - Four states: wait key, sleep, isolate, configure
// - Bus reset forces wait key, CSN zero
// - Wait-for-key command returns to wait key
// - Both CSN clear commands zero the CSN
// - 64-byte SRAM loaded byte-wise at F800H
// - Resource read returns byte, pointer advances one
// - Pointer at length wraps to resource start
// - Reset command asks reload, keeps CSN and state
// - Wait key ignores all Plug and Play accesses
// - Initiation key moves card to sleep
// - Wake zero in sleep starts isolation only for a card with CSN zero
// - Losers of 72 read pairs sleep
// - CSN write moves isolated card to configure
// - Wake zero sleeps configured, isolates CSN zero
// - Reset or any wake sets pointer 1
// - Resources only in configure; match wakes there
// - Isolation winner reads resource data first
// - Status bit0 clears on read, sets again
// - One bit drives 55H/AAH, else senses
// - Bytes shift least significant bit first
`ifndef PNP_CARD_DEFS_SVH
`define PNP_CARD_DEFS_SVH
// ISA fixed ports
`define ISA_ADDR_PORT 12'h279
`define ISA_WDATA_PORT 12'hA79
`define ISA_RD_LOW 2'h3
// Plug and Play register indices
`define IDX_SET_RD 8'h00
`define IDX_ISOLATE 8'h01
`define IDX_CFG_CTRL 8'h02
`define IDX_WAKE 8'h03
`define IDX_RES_DATA 8'h04
`define IDX_STATUS 8'h05
`define IDX_CSN 8'h06
// Configuration control bits
`define CTL_RESET 0
`define CTL_WAIT_KEY 1
`define CTL_CSN_CLR 2
`define CTL_VENDOR_CLR 3
// SRAM layout
`define SRAM_LEN_IDX 6'h00
`define SER_START 6'h01
`define RES_START 6'h0A
`define ISO_BITS 7'h48
`define PAT_FIRST 8'h55
`define PAT_SECOND 8'hAA
`define SHIFT_BITS 4'h8
// Register bus
`define REG_SRAM_PORT 16'hF800
`define REG_CTRL 16'hF804
`define REG_STATUS 16'hF808
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: hdl/pnp_card_pkg.sv
/*
 * Types of the card-side Plug and Play logic.
 * Assumes pnp_card_defs.svh for the numbers.
 */
package pnp_card_pkg;
	// Card state, binary codes
	typedef enum logic [1:0] {
		st_wait_key = 2'h0,
		st_sleep = 2'h1,
		st_isolate = 2'h2,
		st_config = 2'h3
	} pnp_state_t;
	// ISA pin sample carried through the synchroniser
	typedef struct packed {
		logic ior_n;
		logic iow_n;
		logic [11:0] sa;
		logic [7:0] sd;
	} isa_pins_t;
endpackage : pnp_card_pkg

// File: hdl/pnp_card.sv
/*
 * Card-side Plug and Play state machine, isolation and resource data.
 * Assumes an external initiation key comparator on aclk, ISA pins that are
 * asynchronous, and a microcontroller loading the SRAM over AXI4-Lite.
 */
`timescale 1ns/1ps
`include "pnp_card_defs.svh"
module pnp_card #(
	parameter int SRAM_DEPTH = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// ISA pins
	input wire logic isa_ior_n,
	input wire logic isa_iow_n,
	input wire logic [11:0] isa_sa,
	input wire logic [7:0] isa_sd_in,
	output logic [7:0] isa_sd_out,
	output logic isa_sd_oe,
	// Pulse from the initiation key comparator
	input wire logic key_detected
);
	// Card state and handle
	pnp_card_pkg::pnp_state_t state, next_state;
	logic [7:0] csn;
	logic [7:0] pnp_idx;      // Selected register index
	logic [7:0] rd_port;      // READ_DATA port bits [9:2]
	logic load_done;          // Loader finished, card may answer
	logic [5:0] load_ptr;     // Loader write position
	logic [7:0] sram [SRAM_DEPTH];
	logic [5:0] ptr;          // Identifier/resource data pointer
	// Resource byte assembly
	logic ready;
	logic busy;
	logic [3:0] shift_cnt;
	logic [7:0] fetch;
	logic [7:0] res_byte;
	// Isolation progress
	logic [6:0] bit_cnt;
	logic phase;
	logic saw_first;

	// Two-stage synchroniser for the asynchronous ISA pins
	pnp_card_pkg::isa_pins_t pin_s1, pin_s2;
	logic ior_d, iow_d;
	always_ff @(posedge aclk) begin
		pin_s1 <= '{isa_ior_n, isa_iow_n, isa_sa, isa_sd_in};
		pin_s2 <= pin_s1;
	end
	// Strobe history for edge detection, stage two only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ior_d <= 1'b1;
			iow_d <= 1'b1;
		end else begin
			ior_d <= pin_s2.ior_n;
			iow_d <= pin_s2.iow_n;
		end
	end

	// Strobe decode; writes are taken at the trailing edge, where the data
	// has long settled
	wire active = load_done && (state != pnp_card_pkg::st_wait_key);
	wire wr_evt = !iow_d && pin_s2.iow_n;
	wire rd_beg = ior_d && !pin_s2.ior_n;
	wire rd_fin = !ior_d && pin_s2.ior_n;
	wire [7:0] wdata = pin_s2.sd;
	wire rd_hit = pin_s2.sa == {2'h0, rd_port, `ISA_RD_LOW};
	wire wr_addr = wr_evt && active && pin_s2.sa == `ISA_ADDR_PORT;
	wire wr_dat = wr_evt && active && pin_s2.sa == `ISA_WDATA_PORT;
	wire rd_start = rd_beg && active && rd_hit;
	wire rd_end = rd_fin && active && rd_hit;
	wire in_iso = state == pnp_card_pkg::st_isolate;
	wire in_cfg = state == pnp_card_pkg::st_config;
	wire cfg_wr = wr_dat && pnp_idx == `IDX_CFG_CTRL;
	wire wake_wr = wr_dat && pnp_idx == `IDX_WAKE;
	wire csn_wr = wr_dat && pnp_idx == `IDX_CSN && in_iso;
	wire setrd_wr = wr_dat && pnp_idx == `IDX_SET_RD && in_iso;
	wire wfk_cmd = cfg_wr && wdata[`CTL_WAIT_KEY];
	wire rst_cmd = cfg_wr && wdata[`CTL_RESET];
	wire csn_clr = cfg_wr &&
		(wdata[`CTL_CSN_CLR] || wdata[`CTL_VENDOR_CLR]);
	wire wake_match = wake_wr && wdata == csn;
	// Isolation reads
	wire iso_rd = pnp_idx == `IDX_ISOLATE && in_iso &&
		bit_cnt != `ISO_BITS;
	wire [5:0] ser_addr = `SER_START + {2'h0, bit_cnt[6:3]};
	wire iso_bit = sram[ser_addr][bit_cnt[2:0]];
	wire iso_lose = rd_end && iso_rd && phase && !iso_bit && saw_first &&
		pin_s2.sd[1:0] == 2'h2;
	// Resource reads
	wire res_rd = rd_start && in_cfg && pnp_idx == `IDX_RES_DATA;
	wire [7:0] data_len = sram[`SRAM_LEN_IDX];
	wire at_len = {2'h0, ptr} == data_len;
	wire [5:0] ptr_step = at_len ? `RES_START : ptr + 6'h01;
	wire ptr_reload = wake_wr || csn_wr;

	// Card state transitions
	always_comb begin
		next_state = state;
		if (wfk_cmd) begin
			next_state = pnp_card_pkg::st_wait_key;
		end else begin
			unique case (state)
				pnp_card_pkg::st_wait_key: begin
					if (key_detected)
						next_state = pnp_card_pkg::st_sleep;
				end
				pnp_card_pkg::st_sleep: begin
					// Zero CSN isolates, a real CSN selects
					if (wake_match && csn == 8'h00)
						next_state = pnp_card_pkg::st_isolate;
					else if (wake_match)
						next_state = pnp_card_pkg::st_config;
				end
				pnp_card_pkg::st_isolate: begin
					if (csn_wr)
						next_state = pnp_card_pkg::st_config;
					else if (iso_lose || (wake_wr && !wake_match))
						next_state = pnp_card_pkg::st_sleep;
				end
				pnp_card_pkg::st_config: begin
					if (wake_wr && !wake_match)
						next_state = pnp_card_pkg::st_sleep;
				end
			endcase
		end
	end

	// State register, cleared by the bus reset
	always_ff @(posedge aclk) begin
		if (!aresetn)
			state <= pnp_card_pkg::st_wait_key;
		else
			state <= next_state;
	end

	// Card select number; an assignment in the same write wins over nothing
	// else since both commands cannot share one write
	always_ff @(posedge aclk) begin
		if (!aresetn)
			csn <= 8'h00;
		else if (csn_wr)
			csn <= wdata;
		else if (csn_clr)
			csn <= 8'h00;
	end

	// Register index and READ_DATA location
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pnp_idx <= 8'h00;
			rd_port <= 8'h00;
		end else begin
			if (wr_addr)
				pnp_idx <= wdata;
			if (setrd_wr)
				rd_port <= wdata;
		end
	end

	// Data pointer; wake wins over an advance in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ptr <= `SER_START;
		else if (wake_wr)
			ptr <= `SER_START;
		else if (csn_wr)
			ptr <= `RES_START;
		else if (res_rd && ready)
			ptr <= ptr_step;
	end

	// Byte assembly: fetch the byte at the pointer and shift it in over
	// eight cycles; a read clears ready until the next byte is complete
	always_ff @(posedge aclk) begin
		if (!aresetn || ptr_reload || (res_rd && ready)) begin
			ready <= 1'b0;
			busy <= 1'b0;
			shift_cnt <= 4'h0;
		end else if (!ready && !busy && in_cfg) begin
			busy <= 1'b1;
			shift_cnt <= 4'h0;
			fetch <= sram[ptr];
		end else if (busy) begin
			res_byte <= {fetch[shift_cnt[2:0]], res_byte[7:1]};
			shift_cnt <= shift_cnt + 4'h1;
			if (shift_cnt == `SHIFT_BITS - 4'h1) begin
				busy <= 1'b0;
				ready <= 1'b1;
			end
		end
	end

	// Isolation sequencing: decisions at the end of each read, when the
	// other cards' data has certainly settled on the bus
	always_ff @(posedge aclk) begin
		if (!aresetn || wake_wr) begin
			bit_cnt <= 7'h00;
			phase <= 1'b0;
			saw_first <= 1'b0;
		end else if (rd_end && iso_rd) begin
			phase <= !phase;
			if (!phase)
				saw_first <= !iso_bit && pin_s2.sd[1:0] == 2'h1;
			else if (!iso_lose)
				bit_cnt <= bit_cnt + 7'h01;
		end
	end

	// ISA read data: driven from the read's start until the strobe ends
	always_ff @(posedge aclk) begin
		if (!aresetn || rd_fin) begin
			isa_sd_oe <= 1'b0;
			isa_sd_out <= 8'h00;
		end else if (rd_start && iso_rd) begin
			// A zero bit floats the bus and senses the others
			isa_sd_oe <= iso_bit;
			isa_sd_out <= phase ? `PAT_SECOND : `PAT_FIRST;
		end else if (res_rd) begin
			isa_sd_oe <= 1'b1;
			isa_sd_out <= res_byte;
		end else if (rd_start && in_cfg && pnp_idx == `IDX_STATUS) begin
			isa_sd_oe <= 1'b1;
			isa_sd_out <= {7'h00, ready};
		end else if (rd_start && in_cfg && pnp_idx == `IDX_CSN) begin
			isa_sd_oe <= 1'b1;
			isa_sd_out <= csn;
		end
	end

	// Register bus: write address and data held until both arrive
	logic aw_held, w_held;
	logic [15:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire do_wr = aw_held && w_held && !s_axi_bvalid;
	wire wr_sram = do_wr && aw_addr == `REG_SRAM_PORT;
	wire wr_ctrl = do_wr && aw_addr == `REG_CTRL;
	wire wr_ok = wr_sram || wr_ctrl;
	wire [31:0] status_word = {8'h00, 2'h0, ptr, csn, 5'h00, ready, state};
	wire rd_ok = s_axi_araddr == `REG_SRAM_PORT ||
		s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_STATUS;
	wire [31:0] rd_word = s_axi_araddr == `REG_SRAM_PORT ?
		{26'h0, load_ptr} : s_axi_araddr == `REG_CTRL ?
		{31'h0, load_done} : s_axi_araddr == `REG_STATUS ?
		status_word : 32'h0;

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Loader port: one byte per write at an auto-advancing position, so the
	// order of writes is the SRAM layout
	always_ff @(posedge aclk) begin
		if (wr_sram && w_lane0)
			sram[load_ptr] <= w_byte;
	end
	// Loader position and done flag; a reset command asks for a reload
	always_ff @(posedge aclk) begin
		if (!aresetn || rst_cmd) begin
			load_ptr <= 6'h00;
			load_done <= 1'b0;
		end else begin
			if (wr_sram && w_lane0)
				load_ptr <= load_ptr + 6'h01;
			if (wr_ctrl && w_lane0)
				load_done <= w_byte[0];
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_wait_key: assert property (
		$rose(aresetn) |-> state == pnp_card_pkg::st_wait_key &&
			csn == 8'h00 && ptr == `SER_START)
		else $error("reset did not enter wait key");
	a_wait_key_quiet: assert property (
		state == pnp_card_pkg::st_wait_key && !key_detected |=>
			!$rose(isa_sd_oe))
		else $error("card answered in wait key");
	a_key_to_sleep: assert property (
		state == pnp_card_pkg::st_wait_key && key_detected && !wfk_cmd
			|=> state == pnp_card_pkg::st_sleep)
		else $error("key did not reach sleep");
	a_wake_pointer: assert property (
		wake_wr |=> ptr == `SER_START && bit_cnt == 7'h00)
		else $error("wake did not reset pointer");
	a_ready_cycle: assert property (
		res_rd && ready && !ptr_reload |=> !ready ##[9:12] ready)
		else $error("ready not cleared then reset");
	a_ptr_wrap: assert property (
		res_rd && ready && at_len && !ptr_reload |=> ptr == `RES_START)
		else $error("pointer did not wrap");
	a_ptr_step: assert property (
		res_rd && ready && !at_len && !ptr_reload |=>
			ptr == $past(ptr) + 6'h01 && isa_sd_out == $past(res_byte))
		else $error("resource read did not advance");
	a_iso_drive: assert property (
		rd_start && iso_rd && iso_bit && !phase |=>
			isa_sd_oe && isa_sd_out == `PAT_FIRST)
		else $error("isolation one bit not driven");
	a_loser_sleeps: assert property (
		iso_lose && !wfk_cmd |=> state == pnp_card_pkg::st_sleep)
		else $error("losing card did not sleep");
	a_csn_config: assert property (
		csn_wr && !wfk_cmd |=> state == pnp_card_pkg::st_config &&
			ptr == `RES_START)
		else $error("CSN write did not configure");
endmodule : pnp_card

// File: verif/isa_host_model.sv
/*
 * ISA host model that drives Plug and Play reads and writes on the card pins.
 * Assumes the card syncs strobes in 3 clocks and the bus pulls up to FFh.
 */
`timescale 1ns/1ps
`include "pnp_card_defs.svh"
module isa_host_model (
	input wire logic aclk,
	output logic isa_ior_n,
	output logic isa_iow_n,
	output logic [11:0] isa_sa,
	output logic [7:0] isa_sd_in,
	input wire logic [7:0] isa_sd_out,
	input wire logic isa_sd_oe
);
	localparam logic [11:0] RD_PORT = 12'h203; // Read port for value 80h
	logic [7:0] hdat; // Host write data
	logic hdrv; // Host drives the bus
	logic [7:0] rival; // Another card, FFh when nobody drives
	// Wired bus: card first, then host, then rival or pull-up
	assign isa_sd_in = isa_sd_oe ? isa_sd_out : hdrv ? hdat : rival;
	// Idle bus at time zero
	initial begin
		isa_ior_n = 1'b1;
		isa_iow_n = 1'b1;
		isa_sa = 12'h000;
		hdat = 8'h00;
		hdrv = 1'b0;
		rival = 8'hFF;
	end
	// Write cycle; data held well past the synced strobe edge
	task automatic io_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge aclk);
		isa_sa <= a;
		hdat <= d;
		hdrv <= 1'b1;
		isa_iow_n <= 1'b0;
		repeat (4) @(posedge aclk);
		isa_iow_n <= 1'b1;
		repeat (6) @(posedge aclk);
		hdrv <= 1'b0;
	endtask : io_wr
	// Read of the read port; rv is what a rival card drives
	task automatic io_rd(input logic [7:0] rv, output logic [7:0] d);
		@(posedge aclk);
		isa_sa <= RD_PORT;
		rival <= rv;
		isa_ior_n <= 1'b0;
		repeat (6) @(posedge aclk);
		d = isa_sd_in;
		isa_ior_n <= 1'b1;
		repeat (6) @(posedge aclk);
		rival <= 8'hFF;
	endtask : io_rd
	// Index then data, the host's register write
	task automatic pnp_wr(input logic [7:0] i, input logic [7:0] d);
		io_wr(`ISA_ADDR_PORT, i);
		io_wr(`ISA_WDATA_PORT, d);
	endtask : pnp_wr
	// Index then read port, the host's register read
	task automatic pnp_rd(input logic [7:0] i, output logic [7:0] d);
		io_wr(`ISA_ADDR_PORT, i);
		io_rd(8'hFF, d);
	endtask : pnp_rd
endmodule : isa_host_model

// File: verif/pnp_card_tb.sv
/*
 * Self-checking bench for the card Plug and Play logic.
 * Assumes the ISA host model and the card's register bus map.
 */
`timescale 1ns/1ps
`include "pnp_card_defs.svh"
module pnp_card_tb;
	logic aclk = 1'b0;
	logic aresetn, key_detected;
	logic [15:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, isa_ior_n, isa_iow_n, isa_sd_oe;
	logic [11:0] isa_sa;
	logic [7:0] isa_sd_in, isa_sd_out;
	int err_count, compares;
	// Image: length 0Ch, 9 identifier bytes, 3 resource bytes
	logic [7:0] img [0:12] = '{8'h0C, 8'h12, 8'h8C, 8'h00, 8'hFF, 8'h5A,
		8'h01, 8'h80, 8'h3C, 8'hC3, 8'h30, 8'h47, 8'h79};
	localparam logic [31:0] ALL = 32'h003FFF03; // State, csn, pointer
	localparam logic [31:0] SC = 32'h0000FF03; // State and csn
	pnp_card u_pnp_card (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .isa_ior_n, .isa_iow_n,
		.isa_sa, .isa_sd_in, .isa_sd_out, .isa_sd_oe, .key_detected);
	isa_host_model u_isa_host_model (.aclk, .isa_ior_n, .isa_iow_n,
		.isa_sa, .isa_sd_in, .isa_sd_out, .isa_sd_oe);
	// 40 MHz clock
	always #12.5 aclk = ~aclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	// Ready is sampled mid-cycle; it is combinational off held state
	task automatic axi_wr(input logic [15:0] a, input logic [31:0] d);
		logic ta, tw, ha, hw;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		ha = 1'b0;
		hw = 1'b0;
		while (!(ha && hw)) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				ha = 1'b1;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				hw = 1'b1;
			end
		end
		do begin
			@(negedge aclk);
			ta = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end while (!ta);
		s_axi_bready <= 1'b0;
		// Only the loader port and the control word accept writes
		check({30'h0, r}, (a == `REG_SRAM_PORT || a == `REG_CTRL) ?
			{30'h0, `RESP_OKAY} : {30'h0, `RESP_SLVERR});
	endtask : axi_wr
	task automatic axi_rd(input logic [15:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic h;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			h = s_axi_arready;
			@(posedge aclk);
		end while (!h);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			h = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
		end while (!h);
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	function automatic logic [31:0] sw(pnp_card_pkg::pnp_state_t s,
		logic [7:0] c, logic [5:0] p);
		return {10'h000, p, c, 6'h00, s};
	endfunction : sw
	// Status word compared under a field mask
	task automatic chk_st(input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(`REG_STATUS, d, r);
		check(d & m, e & m);
	endtask : chk_st
	task automatic key;
		@(posedge aclk);
		key_detected <= 1'b1;
		@(posedge aclk);
		key_detected <= 1'b0;
	endtask : key
	// Poll ready, then one resource data read
	task automatic rres(input logic [7:0] e);
		logic [7:0] d;
		d = 8'h00;
		for (int k = 0; k < 30 && d[0] !== 1'b1; k++)
			u_isa_host_model.pnp_rd(`IDX_STATUS, d);
		check({31'h0, d[0]}, 32'h1);
		u_isa_host_model.pnp_rd(`IDX_RES_DATA, d);
		check({24'h0, d}, {24'h0, e});
	endtask : rres
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk_st(sw(pnp_card_pkg::st_wait_key, 0, 1), ALL);
		axi_rd(16'hF80C, d, r);
		check({30'h0, r}, {30'h0, `RESP_SLVERR});
		check(d, 32'h0);
		// Unmapped and read-only writes answer with an error
		axi_wr(16'hF80C, 32'h0);
		axi_wr(`REG_STATUS, 32'h0);
	endtask : t_reset
	// Loader order: length, identifier, resources
	task automatic t_load;
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 13; k++)
			axi_wr(`REG_SRAM_PORT, {24'h0, img[k]});
		axi_rd(`REG_SRAM_PORT, d, r);
		check(d, 32'h0000000D);
		axi_wr(`REG_CTRL, 32'h1);
		u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h00);
		chk_st(sw(pnp_card_pkg::st_wait_key, 0, 1), ALL);
		key();
		chk_st(sw(pnp_card_pkg::st_sleep, 0, 1), ALL);
	endtask : t_load
	// First identifier bit is 0 and a rival drives the pair
	task automatic t_lose;
		logic [7:0] d;
		u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h00);
		chk_st(sw(pnp_card_pkg::st_isolate, 0, 1), ALL);
		u_isa_host_model.pnp_wr(`IDX_SET_RD, 8'h80);
		u_isa_host_model.io_wr(`ISA_ADDR_PORT, `IDX_ISOLATE);
		u_isa_host_model.io_rd(8'h55, d);
		u_isa_host_model.io_rd(8'hAA, d);
		chk_st(sw(pnp_card_pkg::st_sleep, 0, 0), SC);
	endtask : t_lose
	task automatic t_win;
		logic [7:0] d;
		logic b;
		u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h00);
		chk_st(sw(pnp_card_pkg::st_isolate, 0, 1), ALL);
		u_isa_host_model.io_wr(`ISA_ADDR_PORT, `IDX_ISOLATE);
		for (int i = 0; i < 72; i++) begin
			b = img[1 + i / 8][i % 8];
			u_isa_host_model.io_rd(8'hFF, d);
			check({24'h0, d}, b ? 32'h55 : 32'hFF);
			u_isa_host_model.io_rd(8'hFF, d);
			check({24'h0, d}, b ? 32'hAA : 32'hFF);
		end
		u_isa_host_model.pnp_wr(`IDX_CSN, 8'h01);
		chk_st(sw(pnp_card_pkg::st_config, 1, 6'h0A), ALL);
	endtask : t_win
	task automatic t_res;
		for (int k = 0; k < 5; k++)
			rres(img[10 + k % 3]);
	endtask : t_res
	task automatic t_wake;
		u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h00);
		chk_st(sw(pnp_card_pkg::st_sleep, 1, 0), SC);
		u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h01);
		chk_st(sw(pnp_card_pkg::st_config, 1, 1), ALL);
		rres(img[1]);
	endtask : t_wake
	// Vendor clear, then standard clear, with re-isolation between
	task automatic t_clear;
		logic [7:0] b;
		logic [31:0] d;
		logic [1:0] r;
		for (int c = 3; c >= 2; c--) begin
			u_isa_host_model.pnp_wr(`IDX_CFG_CTRL, 8'h01 << c);
			chk_st(32'h0, 32'h0000FF00);
			u_isa_host_model.pnp_wr(`IDX_CFG_CTRL, 8'h02);
			chk_st(sw(pnp_card_pkg::st_wait_key, 0, 0), SC);
			key();
			u_isa_host_model.pnp_wr(`IDX_WAKE, 8'h00);
			u_isa_host_model.pnp_wr(`IDX_CSN, 8'h02);
			chk_st(sw(pnp_card_pkg::st_config, 2, 0), SC);
		end
		// Configured card reads back its own number
		u_isa_host_model.pnp_rd(`IDX_CSN, b);
		check({24'h0, b}, 32'h02);
		// Reset command asks the loader for a fresh image
		u_isa_host_model.pnp_wr(`IDX_CFG_CTRL, 8'h01);
		axi_rd(`REG_CTRL, d, r);
		check(d, 32'h0);
		axi_rd(`REG_SRAM_PORT, d, r);
		check(d, 32'h0);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		chk_st(sw(pnp_card_pkg::st_wait_key, 0, 1), ALL);
	endtask : t_clear
	task automatic wrap_up;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up
	// Main sequence after a 3-cycle reset
	initial begin
		aresetn = 1'b0;
		key_detected = 1'b0;
		s_axi_awaddr = 16'h0000;
		s_axi_araddr = 16'h0000;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_load();
		t_lose();
		t_win();
		t_res();
		t_wake();
		t_clear();
		wrap_up();
	end
	// Watchdog well above the expected run length
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		wrap_up();
	end
endmodule : pnp_card_tb
